/* File: hdl/nvm_programming_port.v */
// Summary of operation
// - code c selects one-bit core reset register
// - reset bit holds core reset, unlatched
// - extra reset time-out after bit clears
// - code 4 selects unlock register, checked on update
// - unlock only when register equals signature
// - unlock register clears on power-on reset
// - code 5 command register captures previous result
// - update applies command, idle pass executes it
// - code 6 shifts low command byte
// - load update buffers byte for page write
// - low then high, pre-increment except first
// - code 7 captures bytes, post-increment after high
// - chip erase command sequence and polling
// - flash write entry, address and data prefixes
// - latch data and page write sequences
// - page write completion polled by status bit
// - flash read entry and byte read sequence
// - eeprom write entry, page write, poll
// - eeprom read entry and address loading
// - all shift registers shift lsb first
`timescale 1ns/1ps
`include "nvm_port_regs.vh"
module nvm_programming_port #(
  parameter TIMEOUT_SHORT = `TIMEOUT_SHORT_CYCLES,
  parameter TIMEOUT_LONG  = `TIMEOUT_LONG_CYCLES
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire        tck,
  input  wire        tdi,
  output reg         tdo,
  output wire        tdo_en_n,
  input  wire [3:0]  tap_ir,
  input  wire        tap_capture_dr,
  input  wire        tap_shift_dr,
  input  wire        tap_update_dr,
  input  wire        tap_run_idle,
  input  wire        clk_opt_long,
  output wire        core_reset_n,
  output wire        prog_enabled,
  output reg  [14:0] nvm_ctrl,
  output reg         nvm_ctrl_valid,
  output reg         nvm_exec,
  input  wire [14:0] nvm_result,
  output reg  [7:0]  nvm_mode,
  output reg  [15:0] nvm_addr,
  output reg  [7:0]  nvm_data_low,
  output reg  [7:0]  nvm_data_high,
  input  wire [15:0] flash_word,
  output wire        page_valid,
  input  wire        page_ready,
  output wire [7:0]  page_data,
  output wire        page_high,
  output wire [15:0] page_addr,
  output reg         page_overrun
);
  localparam SYNC_W = 10;
  localparam [SYNC_W-1:0] SYNC_IDLE = 10'h200;

  // pin synchronisers: first stage feeds only the second
  reg [SYNC_W-1:0] sync1;
  reg [SYNC_W-1:0] sync2;
  reg              tck_prev;
  wire             tck_s;
  wire             tdi_s;
  wire [3:0]       ir_s;
  wire             cap_s;
  wire             shf_s;
  wire             upd_s;
  wire             idle_s;
  wire             tck_rise;
  wire             tck_fall;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      // tck idles high; start there so release brings no false edge
      sync1    <= SYNC_IDLE;
      sync2    <= SYNC_IDLE;
      tck_prev <= 1'b1;
    end else begin
      sync1    <= {tck, tdi, tap_ir, tap_capture_dr, tap_shift_dr, tap_update_dr,
                   tap_run_idle};
      sync2    <= sync1;
      tck_prev <= sync2[9];
    end
  end

  assign tck_s    = sync2[9];
  assign tdi_s    = sync2[8];
  assign ir_s     = sync2[7:4];
  assign cap_s    = sync2[3];
  assign shf_s    = sync2[2];
  assign upd_s    = sync2[1];
  assign idle_s   = sync2[0];
  assign tck_rise = tck_s && !tck_prev;
  assign tck_fall = !tck_s && tck_prev;

  wire sel_reset  = (ir_s == `IR_CORE_RESET);
  wire sel_unlock = (ir_s == `IR_NVM_UNLOCK);
  wire sel_cmd    = (ir_s == `IR_NVM_COMMAND);
  wire sel_load   = (ir_s == `IR_PAGE_STREAM_LOAD);
  wire sel_read   = (ir_s == `IR_PAGE_STREAM_READ);

  reg        rst_reg;
  reg [15:0] unlock_reg;
  reg [14:0] cmd_reg;
  reg        bypass_reg;
  reg        upd_prev;
  reg        cap_prev;
  reg        idle_prev;
  reg [3:0]  ir_prev;
  reg        load_high;
  reg        load_first;
  reg        read_high;
  reg        prog_mode;

  // enter-once detection per pass through a state
  wire cap_edge  = tck_rise && cap_s && !cap_prev;
  wire upd_edge  = tck_rise && upd_s && !upd_prev;
  wire idle_edge = tck_rise && idle_s && !idle_prev;
  wire ir_change = (ir_s != ir_prev);

  // compare is latched into prog_mode on update and also gates prog_enabled directly; shifting alone never sets prog_mode
  wire unlock_match = (unlock_reg == `UNLOCK_SIGNATURE);
  assign prog_enabled = prog_mode && unlock_match;

  wire [6:0] op      = cmd_reg[`CMD_OP_MSB:`CMD_OP_LSB];
  wire [7:0] operand = cmd_reg[7:0];

  // two-entry page stream buffer
  wire                       buf_in_ready;
  wire                       buf_push;
  wire [`PL_WORD_WIDTH-1:0]  buf_out;
  wire [15:0]                push_addr;

  assign push_addr = load_first ? nvm_addr :
                     (load_high ? nvm_addr : nvm_addr + 16'h0001);
  assign buf_push  = upd_edge && sel_load && prog_enabled;

  two_entry_buffer #(
    .WIDTH (`PL_WORD_WIDTH),
    .DEPTH (`PL_DEPTH)
  ) page_buffer (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (buf_push),
    .in_ready  (buf_in_ready),
    .in_data   ({load_high, push_addr, cmd_reg[7:0]}),
    .out_valid (page_valid),
    .out_ready (page_ready),
    .out_data  (buf_out)
  );

  assign page_high = buf_out[24];
  assign page_addr = buf_out[23:8];
  assign page_data = buf_out[7:0];

  // data registers, lsb first through each chain
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_reg       <= 1'b0;
      unlock_reg    <= `UNLOCK_RESET;
      cmd_reg       <= `COMMAND_RESET;
      bypass_reg    <= 1'b0;
      upd_prev      <= 1'b0;
      cap_prev      <= 1'b0;
      idle_prev     <= 1'b0;
      ir_prev       <= 4'h0;
      load_high     <= 1'b0;
      load_first    <= 1'b1;
      read_high     <= 1'b0;
      prog_mode     <= 1'b0;
      nvm_ctrl      <= `COMMAND_RESET;
      nvm_ctrl_valid <= 1'b0;
      nvm_exec      <= 1'b0;
      nvm_mode      <= 8'h00;
      nvm_addr      <= 16'h0000;
      nvm_data_low  <= 8'h00;
      nvm_data_high <= 8'h00;
      page_overrun  <= 1'b0;
    end else begin
      nvm_exec <= 1'b0;
      ir_prev  <= ir_s;
      if (tck_rise) begin
        upd_prev  <= upd_s;
        cap_prev  <= cap_s;
        idle_prev <= idle_s;
      end
      if (ir_change) begin
        load_high  <= 1'b0;
        load_first <= 1'b1;
        read_high  <= 1'b0;
      end
      if (cap_edge && sel_cmd) begin
        cmd_reg <= nvm_result;
      end
      if (cap_edge && sel_read && prog_enabled) begin
        cmd_reg[7:0] <= read_high ? flash_word[15:8] : flash_word[7:0];
        read_high    <= !read_high;
        if (read_high) begin
          nvm_addr <= nvm_addr + 16'h0001;
        end
      end
      if (tck_rise && shf_s) begin
        if (sel_reset) begin
          rst_reg <= tdi_s;
        end else if (sel_unlock) begin
          unlock_reg <= {tdi_s, unlock_reg[15:1]};
        end else if (sel_cmd) begin
          cmd_reg <= {tdi_s, cmd_reg[14:1]};
        end else if (sel_load || sel_read) begin
          cmd_reg[7:0] <= {tdi_s, cmd_reg[7:1]};
        end else begin
          bypass_reg <= tdi_s;
        end
      end
      if (upd_edge && sel_unlock) begin
        prog_mode <= unlock_match;
      end
      if (upd_edge && sel_cmd && prog_enabled) begin
        nvm_ctrl       <= cmd_reg;
        nvm_ctrl_valid <= 1'b1;
        case (op)
          `OP_ENTER_MODE: nvm_mode      <= operand;
          `OP_ADDR_HIGH:  nvm_addr[15:8] <= operand;
          `OP_ADDR_LOW:   nvm_addr[7:0]  <= operand;
          `OP_DATA_LOW:   nvm_data_low  <= operand;
          `OP_DATA_HIGH:  nvm_data_high <= operand;
          default:        nvm_mode      <= nvm_mode;
        endcase
      end
      if (!prog_enabled) begin
        nvm_ctrl_valid <= 1'b0;
      end
      // one internal clock per idle pass; latch, write and poll run on it
      if (idle_edge && sel_cmd && prog_enabled && nvm_ctrl_valid) begin
        nvm_exec <= 1'b1;
      end
      if (upd_edge && sel_load && prog_enabled) begin
        if (buf_in_ready) begin
          if (!load_first && !load_high) begin
            nvm_addr <= nvm_addr + 16'h0001;
          end
          load_first <= 1'b0;
          load_high  <= !load_high;
        end else begin
          page_overrun <= 1'b1;
        end
      end
    end
  end

  // tdo changes on the falling tck edge, lsb of the selected chain
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tdo <= 1'b0;
    end else if (tck_fall && shf_s) begin
      if (sel_reset) begin
        tdo <= rst_reg;
      end else if (sel_unlock) begin
        tdo <= unlock_reg[0];
      end else if (sel_cmd || sel_load || sel_read) begin
        tdo <= cmd_reg[0];
      end else begin
        tdo <= bypass_reg;
      end
    end
  end

  reg tdo_drive;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tdo_drive <= 1'b0;
    end else if (tck_fall) begin
      tdo_drive <= shf_s;
    end
  end
  assign tdo_en_n = !tdo_drive;

  // core reset time-out after the reset register clears
  reg [`TIMEOUT_CNT_WIDTH-1:0] to_cnt;
  wire [`TIMEOUT_CNT_WIDTH-1:0] to_load = clk_opt_long ?
                                          TIMEOUT_LONG[`TIMEOUT_CNT_WIDTH-1:0] :
                                          TIMEOUT_SHORT[`TIMEOUT_CNT_WIDTH-1:0];

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      to_cnt <= {`TIMEOUT_CNT_WIDTH{1'b0}};
    end else if (rst_reg) begin
      to_cnt <= to_load;
    end else if (to_cnt != {`TIMEOUT_CNT_WIDTH{1'b0}}) begin
      to_cnt <= to_cnt - {{(`TIMEOUT_CNT_WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // unlatched: the shifting bit reaches the core at once
  assign core_reset_n = !rst_reg && (to_cnt == {`TIMEOUT_CNT_WIDTH{1'b0}});
endmodule

/* File: hdl/nvm_port_regs.vh */
`ifndef NVM_PORT_REGS_VH
`define NVM_PORT_REGS_VH

// instruction codes
`define IR_WIDTH              4
`define IR_CORE_RESET         4'hc
`define IR_NVM_UNLOCK         4'h4
`define IR_NVM_COMMAND        4'h5
`define IR_PAGE_STREAM_LOAD   4'h6
`define IR_PAGE_STREAM_READ   4'h7

// data register widths
`define UNLOCK_WIDTH          16
`define COMMAND_WIDTH         15
`define BYTE_WIDTH            8

// unlock signature and reset value
`define UNLOCK_SIGNATURE      16'ha370
`define UNLOCK_RESET          16'h0000
`define COMMAND_RESET         15'h0000

// command fields: upper seven bits are the opcode, lower eight the operand
`define CMD_OP_MSB            14
`define CMD_OP_LSB            8
`define OP_ENTER_MODE         7'h23
`define OP_ADDR_HIGH          7'h07
`define OP_ADDR_LOW           7'h03
`define OP_DATA_LOW           7'h13
`define OP_DATA_HIGH          7'h17

// mode operands carried with the enter-mode opcode
`define MODE_CHIP_ERASE       8'h80
`define MODE_FLASH_WRITE      8'h10
`define MODE_FLASH_READ       8'h02
`define MODE_EEPROM_WRITE     8'h11
`define MODE_EEPROM_READ      8'h03

// core reset time-out after the reset register clears, per clock option
`define CLK_HZ                100000000
`define TIMEOUT_SHORT_US      65
`define TIMEOUT_LONG_US       4100
`define TIMEOUT_SHORT_CYCLES  ((`TIMEOUT_SHORT_US * (`CLK_HZ / 1000000)))
`define TIMEOUT_LONG_CYCLES   ((`TIMEOUT_LONG_US * (`CLK_HZ / 1000000)))
`define TIMEOUT_CNT_WIDTH     20

// page stream buffer word: high-byte flag, address, data
`define PL_ADDR_WIDTH         16
`define PL_WORD_WIDTH         25
`define PL_DEPTH              2

`endif

/* File: hdl/two_entry_buffer.v */
`timescale 1ns/1ps
module two_entry_buffer #(
  parameter WIDTH = 8,
  parameter DEPTH = 2
) (
  input  wire             clk,
  input  wire             rstn,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [1:0]       wr_ptr;
  reg [1:0]       rd_ptr;
  reg [1:0]       count;
  wire            push;
  wire            pop;
  integer         i;

  assign in_ready  = (count != DEPTH[1:0]);
  assign out_valid = (count != 2'h0);
  assign out_data  = store[rd_ptr[0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= 2'h0;
      rd_ptr <= 2'h0;
      count  <= 2'h0;
      for (i = 0; i < DEPTH; i = i + 1) begin
        store[i] <= {WIDTH{1'b0}};
      end
    end else begin
      if (push) begin
        store[wr_ptr[0]] <= in_data;
        wr_ptr           <= {1'b0, ~wr_ptr[0]};
      end
      if (pop) begin
        rd_ptr <= {1'b0, ~rd_ptr[0]};
      end
      if (push && !pop) begin
        count <= count + 2'h1;
      end else if (pop && !push) begin
        count <= count - 2'h1;
      end
    end
  end
endmodule

/* File: tb/jtag_programmer_model.sv */
`timescale 1ns/1ps
module jtag_programmer_model (
  input  wire       clk,
  input  wire       tdo,
  output reg        tck,
  output reg        tdi,
  output reg  [3:0] tap_ir,
  output reg        tap_capture_dr,
  output reg        tap_shift_dr,
  output reg        tap_update_dr,
  output reg        tap_run_idle
);
  // tck rests high outside frames
  initial {tck, tdi, tap_ir, tap_capture_dr, tap_shift_dr, tap_update_dr, tap_run_idle} = 10'h200;

  // one tck period in state st: fall, 8 clk low, rise, 8 clk high
  task tick(input [3:0] st, input b, output o);
    begin
      @(posedge clk);
      {tap_capture_dr, tap_shift_dr, tap_update_dr, tap_run_idle} <= st;
      tdi <= st[2] ? b : ~tdi;
      tck <= 1'b0;
      repeat (8) @(posedge clk);
      o = tdo;
      tck <= 1'b1;
      repeat (8) @(posedge clk);
    end
  endtask

  // capture, n shifts, update and an optional execute pass
  task scan(input [3:0] ir, input [15:0] d, input integer n, input idle, output [15:0] q);
    integer i;
    reg     o;
    begin
      q = 16'h0000;
      @(posedge clk);
      tap_ir <= ir;
      tick(4'h8, 1'b0, o);
      for (i = 0; i < n; i = i + 1) begin
        tick(4'h4, d[i], o);
        q[i] = o;
      end
      tick(4'h2, 1'b0, o);
      if (idle) tick(4'h1, 1'b0, o);
      @(posedge clk);
      {tap_capture_dr, tap_shift_dr, tap_update_dr, tap_run_idle} <= 4'h0;
    end
  endtask
endmodule

/* File: tb/nvm_port_props.sv */
`timescale 1ns/1ps
module nvm_port_props #(
  parameter TIMEOUT_SHORT = 60,
  parameter TIMEOUT_LONG  = 120
) (
  input wire        clk,
  input wire        rstn,
  input wire        tck,
  input wire        tdo,
  input wire        tdo_en_n,
  input wire        tap_shift_dr,
  input wire        tap_update_dr,
  input wire        tap_run_idle,
  input wire        clk_opt_long,
  input wire        core_reset_n,
  input wire        prog_enabled,
  input wire        nvm_ctrl_valid,
  input wire        nvm_exec,
  input wire        page_valid,
  input wire        page_ready,
  input wire [7:0]  page_data,
  input wire        page_high,
  input wire [15:0] page_addr,
  input wire        page_overrun
);
  reg [19:0] low_cnt;
  always @(posedge clk or negedge rstn)
    if (!rstn) low_cnt <= 20'h00000;
    else low_cnt <= core_reset_n ? 20'h00000 : low_cnt + 20'h00001;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_update_seen;
    $past(tap_update_dr, 2);
  endsequence
  sequence s_idle_seen;
    $past(tap_run_idle, 2) && prog_enabled;
  endsequence

  a_unlock_on_update: assert property ($rose(prog_enabled) |-> s_update_seen)
    else $error("unlock without update");
  a_exec_one_pulse: assert property (nvm_exec |=> !nvm_exec)
    else $error("execute strobe too long");
  a_exec_after_idle: assert property (nvm_exec |-> s_idle_seen)
    else $error("execute without idle pass or unlock");
  a_locked_no_ctrl: assert property (!prog_enabled |-> ##[0:2] !nvm_ctrl_valid)
    else $error("command applied while locked");
  a_page_hold: assert property (page_valid && !page_ready |=> page_valid
    && $stable({page_high, page_addr, page_data}))
    else $error("page word lost under stall");
  a_overrun_sticky: assert property (page_overrun |=> page_overrun)
    else $error("overrun flag dropped");
  a_page_after_update: assert property ($rose(page_valid) |-> s_update_seen)
    else $error("page word without update");
  a_tdo_quiet: assert property (tck [*5] |-> $stable(tdo))
    else $error("tdo moved away from tck fall");
  a_tdo_en_shift: assert property ($fell(tdo_en_n) |-> $past(tap_shift_dr, 3))
    else $error("tdo driven outside shift");
  a_reset_timeout: assert property ($rose(core_reset_n) |->
    low_cnt >= (clk_opt_long ? TIMEOUT_LONG : TIMEOUT_SHORT))
    else $error("core reset time-out too short");
endmodule

bind nvm_programming_port nvm_port_props #(.TIMEOUT_SHORT(TIMEOUT_SHORT),
  .TIMEOUT_LONG(TIMEOUT_LONG)) nvm_port_props_inst (.clk(clk), .rstn(rstn), .tck(tck),
  .tdo(tdo), .tdo_en_n(tdo_en_n), .tap_shift_dr(tap_shift_dr),
  .tap_update_dr(tap_update_dr), .tap_run_idle(tap_run_idle),
  .clk_opt_long(clk_opt_long), .core_reset_n(core_reset_n), .prog_enabled(prog_enabled),
  .nvm_ctrl_valid(nvm_ctrl_valid), .nvm_exec(nvm_exec), .page_valid(page_valid),
  .page_ready(page_ready), .page_data(page_data), .page_high(page_high),
  .page_addr(page_addr), .page_overrun(page_overrun));

/* File: tb/jtag_nvm_programming_port_tb_top.sv */
`timescale 1ns/1ps
module jtag_nvm_programming_port_tb_top;
  localparam [374:0] CMDS = {15'h2380, 15'h3180, 15'h3380, 15'h3380, 15'h3380, 15'h3700,
    15'h7700, 15'h3700, 15'h3700, 15'h3500, 15'h3700, 15'h2302, 15'h3200, 15'h3600, 15'h3700,
    15'h2311, 15'h3300, 15'h3100, 15'h3300, 15'h2303, 15'h2310, 15'h0712, 15'h0334, 15'h13a5,
    15'h175a};
  reg         clk, rstn, clk_opt_long, hold;
  reg         page_ready = 1'b0;
  reg  [14:0] nvm_result;
  reg  [31:0] lfsr = 32'hea7275a1;
  reg  [15:0] q, a;
  reg  [24:0] expq[$];
  integer     i, error_cnt = 0, samples_checked = 0, execs = 0;
  wire        tck, tdi, tdo, tdo_en_n, cap, sh, up, idle, core_reset_n, prog_enabled;
  wire        nvm_ctrl_valid, nvm_exec, page_valid, page_high, page_overrun;
  wire [3:0]  tap_ir;
  wire [14:0] nvm_ctrl;
  wire [7:0]  nvm_mode, nvm_data_low, nvm_data_high, page_data;
  wire [15:0] nvm_addr, page_addr, flash_word;
  // flash model: low byte is the address, high byte its inverse
  assign flash_word = {~nvm_addr[7:0], nvm_addr[7:0]};

  nvm_programming_port #(.TIMEOUT_SHORT(60), .TIMEOUT_LONG(120)) nvm_programming_port_inst (
    .clk(clk), .rstn(rstn), .tck(tck), .tdi(tdi), .tdo(tdo), .tdo_en_n(tdo_en_n),
    .tap_ir(tap_ir), .tap_capture_dr(cap), .tap_shift_dr(sh), .tap_update_dr(up),
    .tap_run_idle(idle), .clk_opt_long(clk_opt_long), .core_reset_n(core_reset_n),
    .prog_enabled(prog_enabled), .nvm_ctrl(nvm_ctrl), .nvm_ctrl_valid(nvm_ctrl_valid),
    .nvm_exec(nvm_exec), .nvm_result(nvm_result), .nvm_mode(nvm_mode), .nvm_addr(nvm_addr),
    .nvm_data_low(nvm_data_low), .nvm_data_high(nvm_data_high), .flash_word(flash_word),
    .page_valid(page_valid), .page_ready(page_ready), .page_data(page_data),
    .page_high(page_high), .page_addr(page_addr), .page_overrun(page_overrun));
  jtag_programmer_model jtag_programmer_model_inst (.clk(clk), .tdo(tdo), .tck(tck),
    .tdi(tdi), .tap_ir(tap_ir), .tap_capture_dr(cap), .tap_shift_dr(sh),
    .tap_update_dr(up), .tap_run_idle(idle));

  function [31:0] step(input [31:0] s);
    step = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input [95:0] nm, input [31:0] e, input [31:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (e !== g) begin
        error_cnt = error_cnt + 1;
        $display("mismatch %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task results;
    begin
      $display("checked %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task sc(input [3:0] ir, input [15:0] d, input integer n, input x);
    jtag_programmer_model_inst.scan(ir, d, n, x, q);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #300000;
    error_cnt = error_cnt + 1;
    results;
  end
  // random stalls on the page sink; checks each delivered word in order
  always @(posedge clk) begin
    lfsr <= step(lfsr);
    page_ready <= !hold && lfsr[3];
    if (nvm_exec === 1'b1) execs = execs + 1;
    if (page_valid === 1'b1 && page_ready === 1'b1) begin
      if (expq.size() == 0) chk("page extra", 0, 1);
      else chk("page word", expq.pop_front(), {page_high, page_addr, page_data});
    end
  end

  initial begin
    rstn = 1'b0;
    clk_opt_long = 1'b0;
    hold = 1'b0;
    nvm_result = 15'h0000;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk("enabled", 0, prog_enabled);
    sc(4'h5, 16'h2310, 15, 1);
    sc(4'h6, 16'h00a5, 8, 0);
    chk("ctrl valid", 0, nvm_ctrl_valid);
    chk("execs", 0, execs);
    $display("locked test done");
    for (i = 0; i < 2; i = i + 1) begin
      clk_opt_long <= i[0];
      sc(4'hc, 16'h0001, 1, 0);
      chk("core reset", 0, core_reset_n);
      sc(4'hc, 16'h0000, 1, 0);
      repeat (i ? 80 : 20) @(posedge clk);
      chk("time-out", 0, core_reset_n);
      repeat (30) @(posedge clk);
      chk("released", 1, core_reset_n);
    end
    sc(4'hc, 16'h0001, 1, 0);
    $display("reset test done");
    sc(4'h4, 16'ha371, 16, 0);
    chk("bad key", 0, prog_enabled);
    sc(4'h4, 16'ha370, 16, 0);
    chk("good key", 1, prog_enabled);
    chk("key out", 16'ha371, q);
    chk("tdo off", 1, tdo_en_n);
    $display("unlock test done");
    for (i = 0; i < 25; i = i + 1) begin
      nvm_result <= lfsr[14:0];
      sc(4'h5, {1'b0, CMDS[(24-i)*15 +: 15]}, 15, 1);
      chk("result", {1'b0, nvm_result}, q);
      chk("ctrl", CMDS[(24 - i) * 15 +: 15], nvm_ctrl);
      chk("execs", i + 1, execs);
    end
    chk("mode", 8'h10, nvm_mode);
    chk("addr", 16'h1234, nvm_addr);
    chk("data", 16'h5aa5, {nvm_data_high, nvm_data_low});
    $display("command test done");
    for (i = 0; i < 4; i = i + 1) begin
      expq.push_back({i[0], 16'h1234 + i[1], 8'h40 + i[7:0]});
      sc(4'h6, 16'h0040 + i, 8, 0);
    end
    repeat (40) @(posedge clk);
    chk("drained", 0, expq.size());
    for (i = 0; i < 4; i = i + 1) begin
      sc(4'h7, 16'h0000, 8, 0);
      a = 16'h1235 + i[1];
      chk("read", a[7:0] ^ {8{i[0]}}, q);
    end
    $display("page test done");
    hold <= 1'b1;
    for (i = 0; i < 3; i = i + 1) begin
      if (i < 2) expq.push_back({i[0], 16'h1237, 8'h70 + i[7:0]});
      sc(4'h6, 16'h0070 + i, 8, 0);
    end
    chk("overrun", 1, page_overrun);
    hold <= 1'b0;
    repeat (40) @(posedge clk);
    chk("drained", 0, expq.size());
    sc(4'h4, 16'h0000, 16, 0);
    chk("relocked", 0, prog_enabled);
    $display("overrun test done");
    results;
  end
endmodule
